// *** design/sacc_top.sv ***
// Purpose: Control logic of a 12-bit successive-approximation converter.
// Assumes: Control pins are asynchronous and pass two flip-flops first.
// Notes: Analog array is outside; this block drives trial bits and reads the comparator.
`timescale 1ns/10ps
`include "sacc_map.svh"

// Contract
// - A low-going read/convert strobe of at least 25 ns starts a conversion and puts the input into hold; the code needs it low at a rising clock edge.
// - Status stays high through the conversion and falls only after the result is latched on the outputs.
// - While status is high the data outputs float and further start strobes are ignored.
// - Tracking of the input resumes as soon as a conversion ends and lasts until the next start.
// - A conversion plus reacquisition completes within 8.5 us for 117 kHz throughput.
// - In stand-alone use the outputs are enabled exactly while read/convert is high and status low.
// - A positive read/convert pulse shows the previous result and its falling edge starts a new one.
// - A short negative pulse floats the outputs at its fall and enables them once conversion ends.
// - The byte/length select is sampled at start; high gives 8 bits, low gives 12 bits.
// - After an 8-bit conversion the four low result bits read as zero.
// - Only the byte/length select is latched; other controls act without storage.
// - Bits are decided most significant first, each trial kept or cleared by the comparator.
// - The result reads as a 12-bit word or as two left-justified bytes.
// - A start comes from whichever of the three start conditions becomes true last.
// - In byte mode select low gives the eight high bits, high gives four low bits and four zeros.
module sacc_top
    import sacc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Control pins.
    input wire sacc_ctrl_t ctrl_pins,
    // Analog array interface.
    input wire logic comparator_high,
    output logic [11:0] trial_bits,
    output logic hold_active,
    // Host outputs.
    output logic status,
    output logic [11:0] result_bits,
    output logic [11:0] result_oe
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    sacc_ctrl_t sync1_reg, sync2_reg, sync3_reg;
    logic cmp1_reg, cmp2_reg;

    // Two stages for every pin; the third stage only feeds edge detection.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            cmp1_reg <= 1'b0;
            cmp2_reg <= 1'b0;
        end else begin
            sync1_reg <= ctrl_pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            cmp1_reg <= comparator_high;
            cmp2_reg <= cmp1_reg;
        end
    end

    // Start condition is a level; its rising edge is the start event.
    function automatic logic start_cond(input sacc_ctrl_t c);
        start_cond = c.chip_enable & ~c.chip_select_n & ~c.read_convert;
    endfunction

    function automatic logic read_cond(input sacc_ctrl_t c);
        read_cond = c.chip_enable & ~c.chip_select_n & c.read_convert;
    endfunction

    logic start_evt;
    assign start_evt = start_cond(sync2_reg) & ~start_cond(sync3_reg);

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    sacc_state_t state_reg, state_next;
    logic [11:0] sar_reg, sar_next;
    logic [3:0] bit_reg, bit_next;
    logic short_reg, short_next;
    logic [11:0] data_reg, data_next;
    logic status_reg, status_next;
    logic hold_reg, hold_next;
    logic [1:0] settle_reg, settle_next;

    always_comb begin
        state_next = state_reg;
        sar_next = sar_reg;
        bit_next = bit_reg;
        short_next = short_reg;
        data_next = data_reg;
        status_next = status_reg;
        hold_next = hold_reg;
        settle_next = settle_reg;
        case (state_reg)
            SACC_IDLE: begin
                if (start_evt) begin
                    short_next = sync2_reg.byte_or_length_select;
                    state_next = SACC_CONV;
                    status_next = 1'b1;
                    hold_next = 1'b1;
                    bit_next = `SACC_MSB_IDX;
                    sar_next = 12'h000;
                    sar_next[`SACC_MSB_IDX] = 1'b1;
                    settle_next = 2'h0;
                end
            end
            SACC_CONV: begin
                // bounded bit time
                // The comparator lags the trial word by its two flops, so each trial waits for its answer.
                if (settle_reg != `SACC_SETTLE_LAST) begin
                    settle_next = settle_reg + 2'h1;
                end else begin
                    settle_next = 2'h0;
                    sar_next[bit_reg] = cmp2_reg;
                    if (bit_reg == (short_reg ? `SACC_LAST_8 : `SACC_LAST_12)) begin
                        hold_next = 1'b0;
                        state_next = SACC_DONE;
                    end else begin
                        bit_next = bit_reg - 4'h1;
                        sar_next[bit_reg - 4'h1] = 1'b1;
                    end
                end
            end
            SACC_DONE: begin
                data_next = sar_reg;
                if (short_reg) begin
                    data_next[3:0] = `SACC_LSB_NIB_ZERO;
                end
                status_next = 1'b0;
                state_next = SACC_IDLE;
            end
            default: begin
                state_next = SACC_IDLE;
                status_next = 1'b0;
                hold_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= SACC_IDLE;
            sar_reg <= 12'h000;
            bit_reg <= 4'h0;
            short_reg <= 1'b0;
            data_reg <= 12'h000;
            status_reg <= 1'b0;
            hold_reg <= 1'b0;
            settle_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            sar_reg <= sar_next;
            bit_reg <= bit_next;
            short_reg <= short_next;
            data_reg <= data_next;
            status_reg <= status_next;
            hold_reg <= hold_next;
            settle_reg <= settle_next;
        end
    end

    // ----------------------------------------
    // Output port
    // ----------------------------------------
    logic [11:0] out_next, oe_next;
    logic [11:0] out_reg, oe_reg;

    // Byte mode puts either byte on the upper eight lines, so a shared 8-bit bus on those lines sees both.
    always_comb begin
        // The latched word is taken from its next value so the pins carry it when status falls.
        out_next = data_next;
        oe_next = 12'h000;
        if (read_cond(sync2_reg) && !status_next) begin
            if (sync2_reg.word_width_sel) begin
                oe_next = 12'hFFF;
            end else begin
                oe_next = 12'hFF0;
                if (sync2_reg.byte_or_length_select) begin
                    out_next = {data_next[3:0], 8'h00};
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_reg <= 12'h000;
            oe_reg <= 12'h000;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign result_bits = out_reg;
    assign result_oe = oe_reg;
    assign status = status_reg;
    assign hold_active = hold_reg;
    assign trial_bits = sar_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence start_seen;
        state_reg == SACC_IDLE && start_evt;
    endsequence

    chk_status_prompt: assert property (@(posedge core_clk) disable iff (rst)
        start_seen |=> status_reg && hold_reg)
        else $error("status did not rise after start");
    chk_conv_bounded: assert property (@(posedge core_clk) disable iff (rst)
        start_seen |=> ##[1:40] !status_reg)
        else $error("conversion too long");
    chk_float_busy: assert property (@(posedge core_clk) disable iff (rst)
        status_reg |-> oe_reg == 12'h000)
        else $error("outputs driven while busy");
    chk_no_restart: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == SACC_CONV && start_evt |=> state_reg != SACC_IDLE && $stable(short_reg))
        else $error("conversion cut short");
    chk_hold_ends: assert property (@(posedge core_clk) disable iff (rst)
        $fell(hold_reg) |-> status_reg)
        else $error("hold released after status fell");
    chk_latch_first: assert property (@(posedge core_clk) disable iff (rst)
        $fell(status_reg) |-> data_reg[11:4] == sar_reg[11:4])
        else $error("status fell before latch");
    chk_short_zero: assert property (@(posedge core_clk) disable iff (rst)
        $fell(status_reg) && short_reg |-> data_reg[3:0] == 4'h0)
        else $error("low bits not zero after short conversion");
    chk_msb_trial: assert property (@(posedge core_clk) disable iff (rst)
        start_seen |=> sar_reg == 12'h800)
        else $error("first trial not most significant");
    chk_read_enable: assert property (@(posedge core_clk) disable iff (rst)
        read_cond(sync2_reg) && sync2_reg.word_width_sel && !status_next |=> oe_reg == 12'hFFF)
        else $error("word read not enabled");
    chk_byte_low: assert property (@(posedge core_clk) disable iff (rst)
        read_cond(sync2_reg) && !sync2_reg.word_width_sel && sync2_reg.byte_or_length_select
            && !status_next |=> out_reg[7:4] == 4'h0)
        else $error("trailing zeros missing");

endmodule // sacc_top

// *** design/sacc_map.svh ***
// Purpose: Named constants for the converter control block.
// Assumes: 20 MHz core clock.
// Notes: Times kept in their own unit; cycle counts derived from them.
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH
`define SACC_CLK_PERIOD_NS 50
`define SACC_THRU_MAX_NS 8500
`define SACC_MIN_LOW_NS 25
`define SACC_MIN_LOW_CYC (((`SACC_MIN_LOW_NS + `SACC_CLK_PERIOD_NS - 1) / `SACC_CLK_PERIOD_NS))
`define SACC_ACQ_NS 2000
`define SACC_ACQ_CYC (`SACC_ACQ_NS / `SACC_CLK_PERIOD_NS)
`define SACC_RES_W 12
`define SACC_MSB_IDX 4'hB
`define SACC_LAST_12 4'h0
`define SACC_LAST_8 4'h4
`define SACC_LSB_NIB_ZERO 4'h0
`define SACC_ACQ_W 7
// The comparator answer passes two flops, so each trial bit is held for three clocks.
`define SACC_SETTLE_LAST 2'h2
`endif

// *** design/sacc_pkg.sv ***
// Purpose: Types for the converter control block.
// Assumes: Included map header gives the widths.
// Notes: Control pins travel as one packed struct.
`include "sacc_map.svh"
package sacc_pkg;
    typedef struct packed {
        logic chip_enable;
        logic chip_select_n;
        logic read_convert;
        logic word_width_sel;
        logic byte_or_length_select;
    } sacc_ctrl_t;
    typedef enum logic [2:0] {
        SACC_IDLE = 3'b001,
        SACC_CONV = 3'b010,
        SACC_DONE = 3'b100
    } sacc_state_t;
endpackage

// *** testbench/sacc_analog_model.sv ***
// Purpose: Behavioural capacitor array and comparator facing the control block.
// Assumes: The analog level is static for the whole of a conversion.
// Notes: The answer is combinational; the block's own two-flop lag absorbs settling.
`timescale 1ns/10ps

module sacc_analog_model (
    // Analog side.
    input wire logic [11:0] analog_level,
    // Array side.
    input wire logic [11:0] trial_bits,
    output logic comparator_high
);
    // comparator trial decision
    // High keeps the trial bit. An ideal comparator is used, so no noise is modelled.
    assign comparator_high = (analog_level >= trial_bits);
endmodule // sacc_analog_model

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the converter control block.
// Assumes: Pins change 2 ns after a rising clock edge.
// Notes: Waits are bounded; a hang ends in the same closing report.
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench;
    import sacc_pkg::*;
    logic core_clk, rst, cmp_hi, hold, status;
    logic [11:0] analog, trial, rbits, roe;
    sacc_ctrl_t pins;
    int bad_count = 0, checks_done = 0, cyc = 0, run_len = 0, last_len = 0;

    sacc_analog_model model (.analog_level(analog), .trial_bits(trial), .comparator_high(cmp_hi));
    sacc_top dut (.core_clk(core_clk), .rst(rst), .ctrl_pins(pins), .comparator_high(cmp_hi),
        .trial_bits(trial), .hold_active(hold), .status(status), .result_bits(rbits), .result_oe(roe));

    // Clock at 50 ns; the falling edge counts how long status stays high.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        cyc++;
        if (status === 1'b1) run_len++;
        else if (run_len != 0) begin last_len = run_len; run_len = 0; end
        // A runaway run is cut short here rather than hanging.
        if (cyc == 3000) begin bad_count++; print_verdict(); end
    end

    task print_verdict();
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task wait_status(input logic lvl);
        int n;
        n = 0;
        while (status !== lvl && n < 60) begin step(1); n++; end
        `CHK(status, lvl)
    endtask

    // Short negative strobe, a second strobe and a length change mid-run.
    task conv_short_pulse(input logic [11:0] v, input logic eight, input logic [11:0] exp, input int len);
        analog = v;
        pins.byte_or_length_select = eight;
        pins.read_convert = 1'b0;
        step(2);
        pins.read_convert = 1'b1;
        wait_status(1'b1);
        `CHK(roe, 12'h000)
        `CHK(hold, 1'b1)
        pins.byte_or_length_select = ~eight;
        pins.read_convert = 1'b0;
        step(2);
        pins.read_convert = 1'b1;
        wait_status(1'b0);
        `CHK(rbits, exp)
        `CHK(hold, 1'b0)
        step(4);
        `CHK(last_len, len)
        `CHK(last_len <= 170, 1'b1)
        `CHK(roe, 12'hFFF)
        `CHK(rbits, exp)
        pins.byte_or_length_select = 1'b0;
    endtask

    // Byte reads of the last result through the upper eight lines.
    task byte_read(input logic sel, input logic [7:0] exp);
        pins.word_width_sel = 1'b0;
        pins.byte_or_length_select = sel;
        step(4);
        `CHK(roe, 12'hFF0)
        `CHK(rbits[11:4], exp)
        pins.word_width_sel = 1'b1;
        pins.byte_or_length_select = 1'b0;
        step(4);
    endtask

    // Positive pulse: old data while high, floating from the fall until high again.
    task conv_long_low(input logic [11:0] v, input logic [11:0] old);
        analog = v;
        `CHK(rbits, old)
        pins.read_convert = 1'b0;
        wait_status(1'b1);
        `CHK(roe, 12'h000)
        wait_status(1'b0);
        step(8);
        `CHK(status, 1'b0)
        `CHK(roe, 12'h000)
        pins.read_convert = 1'b1;
        step(4);
        `CHK(roe, 12'hFFF)
        `CHK(rbits, v)
        pins.chip_select_n = 1'b1;
        step(4);
        `CHK(roe, 12'h000)
        pins.chip_select_n = 1'b0;
    endtask

    // Start taken from chip enable rising last.
    task conv_enable_last(input logic [11:0] v);
        analog = v;
        pins.chip_enable = 1'b0;
        pins.read_convert = 1'b0;
        step(6);
        `CHK(status, 1'b0)
        pins.chip_enable = 1'b1;
        wait_status(1'b1);
        wait_status(1'b0);
        pins.read_convert = 1'b1;
        step(4);
        `CHK(rbits, v)
    endtask

    initial begin
        pins = '{chip_enable: 1'b1, chip_select_n: 1'b0, read_convert: 1'b1,
                 word_width_sel: 1'b1, byte_or_length_select: 1'b0};
        analog = 12'h000;
        rst = 1'b1;
        step(5);
        rst = 1'b0;
        step(2);
        `CHK(status, 1'b0)
        `CHK(roe, 12'h000)
        conv_short_pulse(12'hA5C, 1'b0, 12'hA5C, 37);
        byte_read(1'b0, 8'hA5);
        byte_read(1'b1, 8'hC0);
        conv_short_pulse(12'h3E7, 1'b1, 12'h3E0, 25);
        byte_read(1'b1, 8'h00);
        conv_short_pulse(12'hFFF, 1'b0, 12'hFFF, 37);
        conv_long_low(12'h001, 12'hFFF);
        conv_enable_last(12'h800);
        print_verdict();
    end
endmodule // testbench
